// ### hdl/wake_trim_pkg.sv
package wake_trim_pkg;

	// ==========================================================
	// Serial frame layout (LSB first: address, write flag, data)
	localparam int unsigned FRAME_BITS = 16;
	localparam logic [4:0] FRAME_LAST = 5'h10;
	localparam logic [4:0] ADDR_DONE = 5'h07;
	localparam logic [4:0] DATA_FIRST = 5'h08;
	localparam int unsigned WRITE_FLAG_POS = 7;

	// ==========================================================
	// Register offsets (7-bit serial addresses)
	localparam logic [6:0] ADDR_OSC_FINE_TRIM = 7'h38;
	localparam logic [6:0] ADDR_WAKE_OPTIONS = 7'h39;
	localparam logic [6:0] ADDR_OSC_CAL_HIGH = 7'h3a;
	localparam logic [6:0] ADDR_OSC_CAL_LOW = 7'h3b;
	localparam logic [6:0] ADDR_RECOVERY_CTRL_ONE = 7'h3c;
	localparam logic [6:0] ADDR_RECOVERY_CTRL_TWO = 7'h3d;

	// ==========================================================
	// Field positions
	localparam int unsigned OPT_RX_SEL_POS = 7;
	localparam int unsigned OPT_TRIM_MSB = 4;
	localparam int unsigned CDR1_FILT_LSB = 2;
	localparam int unsigned CDR1_FILT_MSB = 3;
	localparam int unsigned CDR1_EN_POS = 0;
	localparam int unsigned CDR2_CLK_MSB = 1;

	// ==========================================================
	// Reset values and unlock code
	localparam logic [1:0] TRIM_UNLOCK_CODE = 2'h3;
	// Trim presets are factory values; these defaults are arbitrary
	localparam logic [7:0] FINE_TRIM_PRESET = 8'h10;
	localparam logic [4:0] COARSE_TRIM_PRESET = 5'h10;
	localparam logic RX_SEL_RESET = 1'b0;
	localparam logic [7:0] CAL_RESET = 8'h00;
	localparam logic [7:0] CDR1_RESET = 8'h04;
	localparam logic [7:0] CDR2_RESET = 8'h00;

	// ==========================================================
	// Filter time constants and selector codes
	localparam logic [1:0] FILT_SEL_8 = 2'h0;
	localparam logic [1:0] FILT_SEL_16 = 2'h1;
	localparam logic [1:0] FILT_SEL_32 = 2'h2;
	localparam logic [1:0] FILT_SEL_ADAPT = 2'h3;
	localparam logic [5:0] TIME_CONST_8 = 6'h08;
	localparam logic [5:0] TIME_CONST_16 = 6'h10;
	localparam logic [5:0] TIME_CONST_32 = 6'h20;
	localparam logic [3:0] SPACING_SHORT_MIN = 4'h2;
	localparam logic [3:0] SPACING_SHORT_MAX = 4'h3;
	localparam logic [3:0] SPACING_MID_MAX = 4'h8;
	localparam logic [3:0] SPACING_LONG_MAX = 4'ha;

	// ==========================================================
	// Recovery clock frequencies in MHz
	localparam logic [6:0] CLK_MHZ_SEL0 = 7'h50;
	localparam logic [6:0] CLK_MHZ_SEL1 = 7'h28;
	localparam logic [6:0] CLK_MHZ_SEL2 = 7'h14;
	localparam logic [6:0] CLK_MHZ_SEL3 = 7'h0a;

	typedef enum logic [1:0] {
		SPI_IDLE = 2'b01,
		SPI_SHIFT = 2'b10
	} spi_state_type;

endpackage : wake_trim_pkg

// ### hdl/filter_constant_adapt.sv
`timescale 1ns/1ps
module filter_constant_adapt
	import wake_trim_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [1:0] filter_constant_select_i,
	input wire logic edge_spacing_valid_i,
	input wire logic [3:0] edge_spacing_i,
	output logic [5:0] time_constant_o
);

	typedef struct packed {
		logic [5:0] tc;
	} adapt_state_type;

	adapt_state_type s_q;
	adapt_state_type s_d;

	always_comb
	begin
		s_d = s_q;
		case (filter_constant_select_i)
			FILT_SEL_8: s_d.tc = TIME_CONST_8;
			FILT_SEL_16: s_d.tc = TIME_CONST_16;
			FILT_SEL_32: s_d.tc = TIME_CONST_32;
			default:
			begin
				if (edge_spacing_valid_i)
				begin
					if (edge_spacing_i >= SPACING_SHORT_MIN && edge_spacing_i <= SPACING_SHORT_MAX)
						s_d.tc = TIME_CONST_32;
					else if (edge_spacing_i > SPACING_SHORT_MAX && edge_spacing_i <= SPACING_MID_MAX)
						s_d.tc = TIME_CONST_16;
					else if (edge_spacing_i > SPACING_MID_MAX && edge_spacing_i <= SPACING_LONG_MAX)
						s_d.tc = TIME_CONST_8;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			s_q <= '{tc: TIME_CONST_16};
		else
			s_q <= s_d;
	end

	assign time_constant_o = s_q.tc;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_fixed_constant: assert property (
		filter_constant_select_i != FILT_SEL_ADAPT |=> time_constant_o
		== (($past(filter_constant_select_i) == FILT_SEL_8) ? TIME_CONST_8
		: ($past(filter_constant_select_i) == FILT_SEL_16) ? TIME_CONST_16 : TIME_CONST_32))
		else $error("fixed filter constant wrong");
	a_adapt_short: assert property (
		filter_constant_select_i == FILT_SEL_ADAPT && edge_spacing_valid_i
		&& edge_spacing_i inside {[4'h2:4'h3]} |=> time_constant_o == TIME_CONST_32)
		else $error("adapt short spacing wrong");
	a_adapt_long: assert property (
		filter_constant_select_i == FILT_SEL_ADAPT && edge_spacing_valid_i
		&& edge_spacing_i inside {[4'h9:4'ha]} |=> time_constant_o == TIME_CONST_8)
		else $error("adapt long spacing wrong");
	c_adapt_mid: cover property (filter_constant_select_i == FILT_SEL_ADAPT
		&& edge_spacing_valid_i && edge_spacing_i == 4'h6);

endmodule : filter_constant_adapt

// ### hdl/recovery_clock_decode.sv
`timescale 1ns/1ps
module recovery_clock_decode
	import wake_trim_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [1:0] recovery_clock_select_i,
	output logic [6:0] recovery_clock_mhz_o
);

	typedef struct packed {
		logic [6:0] mhz;
	} clk_state_type;

	clk_state_type s_q;
	clk_state_type s_d;

	function automatic logic [6:0] sel_to_mhz(input logic [1:0] sel);
		case (sel)
			2'h0: sel_to_mhz = CLK_MHZ_SEL0;
			2'h1: sel_to_mhz = CLK_MHZ_SEL1;
			2'h2: sel_to_mhz = CLK_MHZ_SEL2;
			default: sel_to_mhz = CLK_MHZ_SEL3;
		endcase
	endfunction : sel_to_mhz

	always_comb
	begin
		s_d = s_q;
		s_d.mhz = sel_to_mhz(recovery_clock_select_i);
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			s_q <= '{mhz: CLK_MHZ_SEL0};
		else
			s_q <= s_d;
	end

	assign recovery_clock_mhz_o = s_q.mhz;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_clock_freq_map: assert property (
		recovery_clock_select_i == 2'h3 |=> recovery_clock_mhz_o == 7'h0a)
		else $error("recovery clock frequency wrong");

endmodule : recovery_clock_decode

// ### hdl/wake_osc_trim_cdr_regs.sv
`timescale 1ns/1ps
module wake_osc_trim_cdr_regs
	import wake_trim_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic soft_reset_i,
	input wire logic restart_i,
	input wire logic [1:0] trim_unlock_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_sclk_i,
	input wire logic spi_sdi_i,
	output logic spi_sdo_o,
	output logic spi_sdo_oe_o,
	input wire logic [7:0] calibration_high_byte_i,
	input wire logic [7:0] calibration_low_byte_i,
	input wire logic edge_spacing_valid_i,
	input wire logic [3:0] edge_spacing_i,
	output logic [12:0] oscillator_trim_code_o,
	output logic wake_receiver_select_o,
	output logic recovery_enable_o,
	output logic [1:0] filter_constant_select_o,
	output logic [5:0] filter_time_constant_o,
	output logic [1:0] recovery_clock_select_o,
	output logic [6:0] recovery_clock_mhz_o
);

	typedef struct packed {
		spi_state_type state;
		logic sclk_last;
		logic [4:0] bit_cnt;
		logic [15:0] in_sh;
		logic [7:0] out_sh;
		logic sdo;
		logic [7:0] fine_trim;
		logic [4:0] coarse_trim;
		logic rx_sel;
		logic [7:0] cal_high;
		logic [7:0] cal_low;
		logic [1:0] filt_sel;
		logic recovery_enable;
		logic [1:0] clk_sel;
	} regs_state_type;

	localparam regs_state_type STATE_RESET = '{
		state: SPI_IDLE,
		sclk_last: 1'b0,
		bit_cnt: 5'h00,
		in_sh: 16'h0000,
		out_sh: 8'h00,
		sdo: 1'b0,
		fine_trim: FINE_TRIM_PRESET,
		coarse_trim: COARSE_TRIM_PRESET,
		rx_sel: RX_SEL_RESET,
		cal_high: CAL_RESET,
		cal_low: CAL_RESET,
		filt_sel: CDR1_RESET[CDR1_FILT_MSB:CDR1_FILT_LSB],
		recovery_enable: CDR1_RESET[CDR1_EN_POS],
		clk_sel: CDR2_RESET[CDR2_CLK_MSB:0]
	};

	regs_state_type s_q;
	regs_state_type s_d;

	logic sclk_rise;
	logic sclk_fall;
	logic frame_done;
	logic frame_write;
	logic unlocked;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;

	// ==========================================================
	// Read decode
	function automatic logic [7:0] reg_read(input logic [6:0] addr, input regs_state_type s);
		if (addr == ADDR_OSC_FINE_TRIM)
			reg_read = s.fine_trim;
		else if (addr == ADDR_WAKE_OPTIONS)
			reg_read = {s.rx_sel, 2'b00, s.coarse_trim};
		else if (addr == ADDR_OSC_CAL_HIGH)
			reg_read = s.cal_high;
		else if (addr == ADDR_OSC_CAL_LOW)
			reg_read = s.cal_low;
		else if (addr == ADDR_RECOVERY_CTRL_ONE)
			reg_read = {4'h0, s.filt_sel, 1'b0, s.recovery_enable};
		else if (addr == ADDR_RECOVERY_CTRL_TWO)
			reg_read = {6'h00, s.clk_sel};
		else
			reg_read = 8'h00;
	endfunction : reg_read

	assign sclk_rise = spi_sclk_i && !s_q.sclk_last;
	assign sclk_fall = !spi_sclk_i && s_q.sclk_last;
	assign frame_done = (s_q.state == SPI_SHIFT) && spi_cs_n_i;
	assign frame_write = frame_done && (s_q.bit_cnt == FRAME_LAST) && s_q.in_sh[WRITE_FLAG_POS];
	assign wr_addr = s_q.in_sh[6:0];
	assign wr_data = s_q.in_sh[15:8];
	assign unlocked = (trim_unlock_i == TRIM_UNLOCK_CODE);

	// ==========================================================
	// Serial port, register writes and resets
	always_comb
	begin
		logic [15:0] shifted;
		shifted = {spi_sdi_i, s_q.in_sh[15:1]};
		s_d = s_q;
		s_d.sclk_last = spi_sclk_i;
		s_d.cal_high = calibration_high_byte_i;
		s_d.cal_low = calibration_low_byte_i;
		case (s_q.state)
			SPI_IDLE:
			begin
				if (!spi_cs_n_i)
				begin
					s_d.state = SPI_SHIFT;
					s_d.bit_cnt = 5'h00;
					s_d.sdo = 1'b0;
				end
			end
			SPI_SHIFT:
			begin
				if (spi_cs_n_i)
					s_d.state = SPI_IDLE;
				else
				begin
					if (sclk_rise && s_q.bit_cnt != FRAME_LAST)
					begin
						s_d.in_sh = shifted;
						s_d.bit_cnt = s_q.bit_cnt + 5'h01;
						if (s_q.bit_cnt == ADDR_DONE)
							s_d.out_sh = reg_read(shifted[14:8], s_q);
					end
					if (sclk_fall && s_q.bit_cnt >= DATA_FIRST && s_q.bit_cnt != FRAME_LAST)
					begin
						s_d.sdo = s_q.out_sh[0];
						s_d.out_sh = {1'b0, s_q.out_sh[7:1]};
					end
				end
			end
			default: s_d.state = SPI_IDLE;
		endcase
		if (frame_write)
		begin
			if (wr_addr == ADDR_OSC_FINE_TRIM && unlocked)
				s_d.fine_trim = wr_data;
			else if (wr_addr == ADDR_WAKE_OPTIONS && unlocked)
			begin
				s_d.coarse_trim = wr_data[OPT_TRIM_MSB:0];
				s_d.rx_sel = wr_data[OPT_RX_SEL_POS];
			end
			else if (wr_addr == ADDR_RECOVERY_CTRL_ONE)
			begin
				s_d.filt_sel = wr_data[CDR1_FILT_MSB:CDR1_FILT_LSB];
				s_d.recovery_enable = wr_data[CDR1_EN_POS];
			end
			else if (wr_addr == ADDR_RECOVERY_CTRL_TWO)
				s_d.clk_sel = wr_data[CDR2_CLK_MSB:0];
		end
		if (restart_i)
			s_d.recovery_enable = 1'b0;
		if (soft_reset_i)
		begin
			s_d.fine_trim = FINE_TRIM_PRESET;
			s_d.coarse_trim = COARSE_TRIM_PRESET;
			s_d.rx_sel = RX_SEL_RESET;
			s_d.cal_high = CAL_RESET;
			s_d.cal_low = CAL_RESET;
			s_d.filt_sel = CDR1_RESET[CDR1_FILT_MSB:CDR1_FILT_LSB];
			s_d.recovery_enable = CDR1_RESET[CDR1_EN_POS];
			s_d.clk_sel = CDR2_RESET[CDR2_CLK_MSB:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			s_q <= STATE_RESET;
		else
			s_q <= s_d;
	end

	// ==========================================================
	// Outputs and helpers
	assign spi_sdo_o = s_q.sdo;
	assign spi_sdo_oe_o = !spi_cs_n_i;
	assign oscillator_trim_code_o = {s_q.coarse_trim, s_q.fine_trim};
	assign wake_receiver_select_o = s_q.rx_sel;
	assign recovery_enable_o = s_q.recovery_enable;
	assign filter_constant_select_o = s_q.filt_sel;
	assign recovery_clock_select_o = s_q.clk_sel;

	filter_constant_adapt u_filter_adapt (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.filter_constant_select_i(s_q.filt_sel),
		.edge_spacing_valid_i(edge_spacing_valid_i),
		.edge_spacing_i(edge_spacing_i),
		.time_constant_o(filter_time_constant_o)
	);

	recovery_clock_decode u_clock_decode (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.recovery_clock_select_i(s_q.clk_sel),
		.recovery_clock_mhz_o(recovery_clock_mhz_o)
	);

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_fine_trim_lock: assert property (
		frame_write && wr_addr == ADDR_OSC_FINE_TRIM && !unlocked && !soft_reset_i
		|=> $stable(oscillator_trim_code_o[7:0]))
		else $error("locked fine trim changed");
	a_fine_trim_write: assert property (
		frame_write && wr_addr == ADDR_OSC_FINE_TRIM && unlocked && !soft_reset_i
		|=> oscillator_trim_code_o[7:0] == $past(wr_data))
		else $error("unlocked fine trim not written");
	a_coarse_trim_lock: assert property (
		frame_write && wr_addr == ADDR_WAKE_OPTIONS && !unlocked && !soft_reset_i
		|=> $stable(oscillator_trim_code_o[12:8]) && $stable(wake_receiver_select_o))
		else $error("locked options changed");
	a_rx_select_write: assert property (
		frame_write && wr_addr == ADDR_WAKE_OPTIONS && unlocked && !soft_reset_i
		|=> wake_receiver_select_o == $past(wr_data[7])
		&& oscillator_trim_code_o[12:8] == $past(wr_data[4:0]))
		else $error("options write lost");
	a_reserved_read_zero: assert property (
		reg_read(ADDR_RECOVERY_CTRL_ONE, s_q)[7:4] == 4'h0
		&& reg_read(ADDR_RECOVERY_CTRL_ONE, s_q)[1] == 1'b0
		&& reg_read(ADDR_RECOVERY_CTRL_TWO, s_q)[7:2] == 6'h00
		&& reg_read(ADDR_WAKE_OPTIONS, s_q)[6:5] == 2'b00)
		else $error("reserved bit reads one");
	a_cal_reset_zero: assert property (
		$rose(rst_n_i) || $past(soft_reset_i)
		|-> reg_read(ADDR_OSC_CAL_HIGH, s_q) == 8'h00 && reg_read(ADDR_OSC_CAL_LOW, s_q) == 8'h00)
		else $error("calibration not zero after reset");
	a_cdr_one_reset: assert property (
		$rose(rst_n_i) || $past(soft_reset_i)
		|-> reg_read(ADDR_RECOVERY_CTRL_ONE, s_q) == 8'h04 && !recovery_enable_o)
		else $error("control one reset value wrong");
	a_options_reset: assert property (
		soft_reset_i |=> reg_read(ADDR_WAKE_OPTIONS, s_q)[7:5] == 3'b000)
		else $error("options select not cleared");
	a_enable_write: assert property (
		frame_write && wr_addr == ADDR_RECOVERY_CTRL_ONE && !soft_reset_i && !restart_i
		|=> recovery_enable_o == $past(wr_data[0])
		&& filter_constant_select_o == $past(wr_data[3:2]))
		else $error("control one write lost");
	a_clock_select_write: assert property (
		frame_write && wr_addr == ADDR_RECOVERY_CTRL_TWO && !soft_reset_i
		|=> recovery_clock_select_o == $past(wr_data[1:0]))
		else $error("clock select write lost");
	c_unlocked_trim: cover property (frame_write && wr_addr == ADDR_OSC_FINE_TRIM && unlocked);
	c_locked_trim: cover property (frame_write && wr_addr == ADDR_WAKE_OPTIONS && !unlocked);
	c_adapt_enabled: cover property (recovery_enable_o && filter_constant_select_o == FILT_SEL_ADAPT);
	c_read_frame: cover property (frame_done && !s_q.in_sh[WRITE_FLAG_POS]);

endmodule : wake_osc_trim_cdr_regs

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	import wake_trim_pkg::*;
	logic clk, rst_n, soft_reset, restart, cs_n, sclk, sdi, sp_valid;
	logic [1:0] unlock;
	logic [7:0] cal_h, cal_l, rdq;
	logic [3:0] spacing;
	logic sdo, sdo_oe, rx_sel, recovery_enable;
	logic [12:0] trim;
	logic [1:0] filt_sel, clk_sel;
	logic [5:0] tconst;
	logic [6:0] mhz;
	int mismatches;
	int tests_run;
	logic [5:0] tc_tab [3] = '{6'h08, 6'h10, 6'h20};
	logic [6:0] mhz_tab [4] = '{7'h50, 7'h28, 7'h14, 7'h0a};
	logic [3:0] sp_tab [8] = '{4'h2, 4'h9, 4'h4, 4'h3, 4'ha, 4'hc, 4'h1, 4'h8};
	logic [5:0] sp_exp [8] = '{6'h20, 6'h08, 6'h10, 6'h20, 6'h08, 6'h08, 6'h08, 6'h10};

	wake_osc_trim_cdr_regs wake_osc_trim_cdr_regs_i (
		.clk_i(clk), .rst_n_i(rst_n), .soft_reset_i(soft_reset), .restart_i(restart),
		.trim_unlock_i(unlock), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_sdi_i(sdi),
		.spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .calibration_high_byte_i(cal_h),
		.calibration_low_byte_i(cal_l), .edge_spacing_valid_i(sp_valid),
		.edge_spacing_i(spacing), .oscillator_trim_code_o(trim),
		.wake_receiver_select_o(rx_sel), .recovery_enable_o(recovery_enable),
		.filter_constant_select_o(filt_sel), .filter_time_constant_o(tconst),
		.recovery_clock_select_o(clk_sel), .recovery_clock_mhz_o(mhz)
	);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ==========================================================
	// Comparison and closing
	task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (!(got === exp))
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task summarize();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize

	// ==========================================================
	// Serial frame: sdo sampled at the end of the low phase before each data bit
	task frame(input logic [6:0] a, input logic w, input logic [7:0] d, input int n);
		logic [15:0] bits;
		bits = {d, w, a};
		rdq = 8'h00;
		@(negedge clk);
		cs_n = 1'b0;
		@(negedge clk);
		chk("sdo enable", 16'h1, {15'h0, sdo_oe});
		for (int i = 0; i < n; i++)
		begin
			if (i >= 8)
				rdq[i-8] = sdo;
			sdi = bits[i];
			sclk = 1'b1;
			repeat (2) @(negedge clk);
			sclk = 1'b0;
			repeat (2) @(negedge clk);
		end
		cs_n = 1'b1;
		repeat (3) @(negedge clk);
		chk("sdo enable", 16'h0, {15'h0, sdo_oe});
	endtask : frame

	task wr(input logic [6:0] a, input logic [7:0] d);
		frame(a, 1'b1, d, 16);
	endtask : wr

	task rd(input logic [6:0] a, input logic [7:0] e);
		frame(a, 1'b0, 8'h00, 16);
		chk($sformatf("register %h", a), {8'h00, e}, {8'h00, rdq});
	endtask : rd

	task outs(input logic [12:0] t, input logic r, input logic en, input logic [1:0] fs);
		chk("trim code", {3'h0, t}, {3'h0, trim});
		chk("receiver select", {15'h0, r}, {15'h0, rx_sel});
		chk("recovery enable", {15'h0, en}, {15'h0, recovery_enable});
		chk("filter select", {14'h0, fs}, {14'h0, filt_sel});
	endtask : outs

	// ==========================================================
	// Main sequence
	initial
	begin
		mismatches = 0;
		tests_run = 0;
		{rst_n, soft_reset, restart, sclk, sdi, sp_valid} = 6'h00;
		cs_n = 1'b1;
		unlock = 2'h0;
		cal_h = 8'h00;
		cal_l = 8'h00;
		spacing = 4'h0;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		outs({COARSE_TRIM_PRESET, FINE_TRIM_PRESET}, 1'b0, 1'b0, 2'h1);
		chk("time constant", 16'h10, {10'h0, tconst});
		chk("clock mhz", 16'h50, {9'h0, mhz});
		rd(ADDR_OSC_FINE_TRIM, FINE_TRIM_PRESET);
		rd(ADDR_WAKE_OPTIONS, {3'h0, COARSE_TRIM_PRESET});
		rd(ADDR_OSC_CAL_HIGH, 8'h00);
		rd(ADDR_OSC_CAL_LOW, 8'h00);
		rd(ADDR_RECOVERY_CTRL_ONE, 8'h04);
		rd(ADDR_RECOVERY_CTRL_TWO, 8'h00);
		// Every locked unlock code
		for (int k = 0; k < 3; k++)
		begin
			unlock = k[1:0];
			wr(ADDR_OSC_FINE_TRIM, 8'ha5);
			wr(ADDR_WAKE_OPTIONS, 8'h9f);
			rd(ADDR_OSC_FINE_TRIM, FINE_TRIM_PRESET);
			rd(ADDR_WAKE_OPTIONS, {3'h0, COARSE_TRIM_PRESET});
		end
		unlock = 2'h3;
		wr(ADDR_OSC_FINE_TRIM, 8'ha5);
		wr(ADDR_WAKE_OPTIONS, 8'hff);
		rd(ADDR_OSC_FINE_TRIM, 8'ha5);
		rd(ADDR_WAKE_OPTIONS, 8'h9f);
		outs(13'h1fa5, 1'b1, 1'b0, 2'h1);
		// Calibration bytes ignore writes and show the inputs
		cal_h = 8'h5a;
		cal_l = 8'hc3;
		wr(ADDR_OSC_CAL_HIGH, 8'hff);
		wr(ADDR_OSC_CAL_LOW, 8'h00);
		rd(ADDR_OSC_CAL_HIGH, 8'h5a);
		rd(ADDR_OSC_CAL_LOW, 8'hc3);
		wr(ADDR_RECOVERY_CTRL_ONE, 8'hff);
		rd(ADDR_RECOVERY_CTRL_ONE, 8'h0d);
		outs(13'h1fa5, 1'b1, 1'b1, 2'h3);
		for (int k = 0; k < 3; k++)
		begin
			wr(ADDR_RECOVERY_CTRL_ONE, {4'h0, k[1:0], 2'h0});
			chk("time constant", {10'h0, tc_tab[k]}, {10'h0, tconst});
			chk("recovery enable", 16'h0, {15'h0, recovery_enable});
		end
		// Adaptive filter constant from edge spacing
		wr(ADDR_RECOVERY_CTRL_ONE, 8'h0c);
		for (int k = 0; k < 8; k++)
		begin
			spacing = sp_tab[k];
			sp_valid = 1'b1;
			@(negedge clk);
			sp_valid = 1'b0;
			repeat (2) @(negedge clk);
			chk("adapt constant", {10'h0, sp_exp[k]}, {10'h0, tconst});
		end
		for (int k = 0; k < 4; k++)
		begin
			wr(ADDR_RECOVERY_CTRL_TWO, 8'hfc | 8'(k));
			rd(ADDR_RECOVERY_CTRL_TWO, 8'(k));
			chk("clock select", 16'(k), {14'h0, clk_sel});
			chk("clock mhz", {9'h0, mhz_tab[k]}, {9'h0, mhz});
		end
		// Unmapped read and a short frame are refused
		rd(7'h40, 8'h00);
		frame(ADDR_RECOVERY_CTRL_TWO, 1'b1, 8'h01, 15);
		rd(ADDR_RECOVERY_CTRL_TWO, 8'h03);
		// Restart drops only the enable
		wr(ADDR_RECOVERY_CTRL_ONE, 8'h09);
		chk("recovery enable", 16'h1, {15'h0, recovery_enable});
		restart = 1'b1;
		@(negedge clk);
		restart = 1'b0;
		repeat (2) @(negedge clk);
		outs(13'h1fa5, 1'b1, 1'b0, 2'h2);
		chk("clock select", 16'h3, {14'h0, clk_sel});
		soft_reset = 1'b1;
		@(negedge clk);
		soft_reset = 1'b0;
		repeat (2) @(negedge clk);
		outs({COARSE_TRIM_PRESET, FINE_TRIM_PRESET}, 1'b0, 1'b0, 2'h1);
		rd(ADDR_RECOVERY_CTRL_ONE, 8'h04);
		rd(ADDR_RECOVERY_CTRL_TWO, 8'h00);
		// Recommended use: keep coefficient and coarse bits, pick low-power receiver
		wr(ADDR_OSC_FINE_TRIM, {FINE_TRIM_PRESET[7:5], 5'h0c});
		wr(ADDR_WAKE_OPTIONS, {3'h4, COARSE_TRIM_PRESET});
		wr(ADDR_RECOVERY_CTRL_ONE, 8'h0d);
		rd(ADDR_WAKE_OPTIONS, {3'h4, COARSE_TRIM_PRESET});
		outs({COARSE_TRIM_PRESET, FINE_TRIM_PRESET[7:5], 5'h0c}, 1'b1, 1'b1, 2'h3);
		summarize();
	end

	initial
	begin
		repeat (30000) @(posedge clk);
		mismatches++;
		summarize();
	end
endmodule : testbench
